// *** logic/opm_ctrl.sv ***
// Operating mode, clock gating and wake-up controller.
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module opm_ctrl
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [opm_pkg::ADDR_W-1:0] addr,
	input wire logic [opm_pkg::DATA_W-1:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [opm_pkg::DATA_W-1:0] rdata,
	input wire logic halt_exec,
	input wire logic clr_wdt_exec,
	input wire logic ext_rst_pin_n,
	input wire logic [opm_pkg::NPA-1:0] porta_pins,
	input wire logic [opm_pkg::NIRQ-1:0] irq_req,
	input wire logic [opm_pkg::NIRQ-1:0] irq_en,
	input wire logic stack_full,
	input wire logic wdt_enabled,
	input wire logic wdt_overflow,
	input wire logic [opm_pkg::NOSC-1:0] osc_rdy,
	output logic [opm_pkg::NOSC-1:0] osc_en,
	output logic int_low_osc_en,
	output logic [1:0] int_high_osc_freq_sel,
	output logic high_clk_on,
	output logic sub_clk_on,
	output logic cpu_clk_on,
	output logic sys_on_sub,
	output logic [2:0] sys_div_sel,
	output logic fast_src,
	output logic state_hold,
	output logic wdt_clear,
	output logic wdt_run,
	output logic sys_reset_req,
	output logic wdt_reset_req,
	output logic resume_next,
	output logic irq_take
);
	import opm_pkg::*;

	function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
		return a == off;
	endfunction

	opm_mode_t mode_reg, mode_next;
	opm_wake_t cause_reg, cause_next;
	logic [7:0] scc_reg;
	logic int_high_osc_en_reg;
	logic [1:0] int_high_osc_freq_reg;
	logic hxt_en_reg;
	logic lxt_en_reg;
	logic [NPA-1:0] porta_wake_en_reg;
	logic [NPA-1:0] pa_prev_reg;
	logic [NIRQ-1:0] irq_mask_reg;
	logic pdf_reg, pdf_next;
	logic to_reg, to_next;
	logic on_sub_reg, on_sub_next;
	logic [7:0] rdata_reg;
	logic wdt_clear_reg;
	logic sys_reset_reg;
	logic wdt_reset_reg;
	logic resume_reg;
	logic irq_take_reg;
	logic [NOSC-1:0] stable;

	opm_osc_if osc_if[NOSC]();

	wire wr_scc = wr_stb & hit(addr, OFF_SYS_CLOCK_CTRL);
	wire wr_int_high_osc = wr_stb & hit(addr, OFF_INT_HIGH_OSC_CTRL);
	wire wr_hxt = wr_stb & hit(addr, OFF_EXT_HIGH_OSC_CTRL);
	wire wr_lxt = wr_stb & hit(addr, OFF_EXT_LOW_OSC_CTRL);
	wire wr_porta_wake_en = wr_stb & hit(addr, OFF_PORTA_WAKE_EN);

	wire [2:0] div_field = scc_reg[SCC_DIV_HI:SCC_DIV_LO];
	wire fast_clk_src_sel = scc_reg[SCC_FAST_SRC];
	wire slow_clk_src_sel = scc_reg[SCC_SLOW_SRC];
	wire hs_osc_halt_keep = scc_reg[SCC_HS_KEEP];
	wire ls_osc_halt_keep = scc_reg[SCC_LS_KEEP];
	wire target_sub = (div_field == DIV_SUB);

	wire int_high_osc_stable = stable[OSC_INT_HIGH_OSC];
	wire ext_high_osc_stable = stable[OSC_HXT];
	wire high_stable = fast_clk_src_sel ? ext_high_osc_stable
		: int_high_osc_stable;
	// The internal low oscillator has no ready indication of its own.
	wire sub_stable = slow_clk_src_sel ? stable[OSC_LXT] : 1'b1;
	wire tgt_stable = target_sub ? sub_stable : high_stable;
	wire sys_stable = on_sub_reg ? sub_stable : high_stable;

	wire low_pwr = (mode_reg == OPM_SLEEP) || (mode_reg == OPM_IDLE_SUB_ONLY)
		|| (mode_reg == OPM_IDLE_BOTH_CLOCKS) || (mode_reg == OPM_IDLE_HIGH_ONLY);
	wire allow_high = (mode_reg == OPM_RUN) || (mode_reg == OPM_SWITCH)
		|| (mode_reg == OPM_WAKE) || (mode_reg == OPM_IDLE_BOTH_CLOCKS)
		|| (mode_reg == OPM_IDLE_HIGH_ONLY);
	wire allow_sub = (mode_reg == OPM_RUN) || (mode_reg == OPM_SWITCH)
		|| (mode_reg == OPM_WAKE) || (mode_reg == OPM_IDLE_SUB_ONLY)
		|| (mode_reg == OPM_IDLE_BOTH_CLOCKS);

	wire halt_take = (mode_reg == OPM_RUN) & halt_exec;
	wire [NPA-1:0] pa_fall = pa_prev_reg & ~porta_pins & porta_wake_en_reg;
	// Requests already raised at halt are masked out of the wake decision.
	wire [NIRQ-1:0] irq_new = irq_req & ~irq_mask_reg;
	wire irq_wake = |irq_new;
	wire irq_serve = (|(irq_new & irq_en)) & ~stack_full;
	wire rst_wake = ~ext_rst_pin_n;
	wire any_wake = rst_wake | wdt_overflow | irq_wake | (|pa_fall);
	wire int_high_osc_restart = wr_int_high_osc & int_high_osc_en_reg
		& (wdata[INT_HIGH_OSC_FREQ_HI:INT_HIGH_OSC_FREQ_LO] != int_high_osc_freq_reg);

	wire [NOSC-1:0] osc_en_w = {lxt_en_reg & allow_sub,
		hxt_en_reg & allow_high, int_high_osc_en_reg & allow_high};

	genvar g;
	generate
		for (g = 0; g < NOSC; g = g + 1)
		begin : g_osc
			assign osc_if[g].en = osc_en_w[g];
			assign osc_if[g].restart = (g == OSC_INT_HIGH_OSC) ? int_high_osc_restart : 1'b0;
			assign osc_if[g].rdy = osc_rdy[g];
			assign stable[g] = osc_if[g].stable;
			opm_osc_stable u_trk
			(
				.clk(clk),
				.reset(reset),
				.osc(osc_if[g].trk)
			);
		end
	endgenerate

	always_comb
	begin
		mode_next = mode_reg;
		cause_next = cause_reg;
		on_sub_next = on_sub_reg;
		unique case (mode_reg)
			OPM_RUN:
			begin
				if (halt_exec)
				begin
					if (!hs_osc_halt_keep && !ls_osc_halt_keep)
						mode_next = OPM_SLEEP;
					else if (!hs_osc_halt_keep)
						mode_next = OPM_IDLE_SUB_ONLY;
					else if (ls_osc_halt_keep)
						mode_next = OPM_IDLE_BOTH_CLOCKS;
					else
						mode_next = OPM_IDLE_HIGH_ONLY;
				end
				else if (target_sub != on_sub_reg && tgt_stable)
					mode_next = OPM_SWITCH;
			end
			OPM_SWITCH:
			begin
				// One gated cycle around the source change keeps it glitch-free.
				on_sub_next = target_sub;
				mode_next = OPM_RUN;
			end
			OPM_SLEEP, OPM_IDLE_SUB_ONLY, OPM_IDLE_BOTH_CLOCKS, OPM_IDLE_HIGH_ONLY:
			begin
				if (any_wake)
				begin
					mode_next = OPM_WAKE;
					if (rst_wake)
						cause_next = WK_RESET;
					else if (wdt_overflow)
						cause_next = WK_WDT;
					else if (irq_serve)
						cause_next = WK_IRQ;
					else
						cause_next = WK_RESUME;
				end
			end
			OPM_WAKE:
			begin
				if (sys_stable)
					mode_next = OPM_RUN;
			end
			default:
				mode_next = OPM_RUN;
		endcase
	end

	// Set wins over clear on both status flags.
	assign pdf_next = halt_take ? 1'b1
		: (clr_wdt_exec ? 1'b0 : pdf_reg);
	assign to_next = wdt_overflow ? 1'b1
		: (halt_take ? 1'b0 : to_reg);

	wire wake_done = (mode_reg == OPM_WAKE) & sys_stable;

	wire [7:0] rd_scc = scc_reg & SCC_MASK;
	wire [7:0] rd_int_high_osc = {4'h0, int_high_osc_freq_reg, int_high_osc_stable, int_high_osc_en_reg};
	wire [7:0] rd_hxt = {6'h00, ext_high_osc_stable, hxt_en_reg};
	wire [7:0] rd_lxt = LXT_READ_ONE | {6'h00, stable[OSC_LXT], lxt_en_reg};
	wire [7:0] rd_stat = {3'h0, mode_reg, to_reg, pdf_reg};
	wire [7:0] rd_mux = hit(addr, OFF_SYS_CLOCK_CTRL) ? rd_scc
		: hit(addr, OFF_INT_HIGH_OSC_CTRL) ? rd_int_high_osc
		: hit(addr, OFF_EXT_HIGH_OSC_CTRL) ? rd_hxt
		: hit(addr, OFF_EXT_LOW_OSC_CTRL) ? rd_lxt
		: hit(addr, OFF_STATUS) ? rd_stat
		: hit(addr, OFF_PORTA_WAKE_EN) ? porta_wake_en_reg
		: 8'h00;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			scc_reg <= SCC_RST;
			int_high_osc_en_reg <= INT_HIGH_OSC_EN_RST;
			int_high_osc_freq_reg <= INT_HIGH_OSC_FREQ_RST;
			hxt_en_reg <= HXT_EN_RST;
			lxt_en_reg <= LXT_EN_RST;
			porta_wake_en_reg <= PORTA_WAKE_EN_RST;
		end
		else
		begin
			if (wr_scc)
				scc_reg <= wdata & SCC_MASK;
			if (wr_int_high_osc)
			begin
				int_high_osc_en_reg <= wdata[OSC_EN_BIT];
				int_high_osc_freq_reg <= wdata[INT_HIGH_OSC_FREQ_HI:INT_HIGH_OSC_FREQ_LO];
			end
			if (wr_hxt)
				hxt_en_reg <= wdata[OSC_EN_BIT];
			if (wr_lxt)
				lxt_en_reg <= wdata[OSC_EN_BIT];
			if (wr_porta_wake_en)
				porta_wake_en_reg <= wdata;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			mode_reg <= OPM_RUN;
			cause_reg <= WK_RESUME;
			on_sub_reg <= 1'b0;
			pdf_reg <= 1'b0;
			to_reg <= 1'b0;
			pa_prev_reg <= {NPA{1'b1}};
			irq_mask_reg <= {NIRQ{1'b0}};
			rdata_reg <= 8'h00;
		end
		else
		begin
			mode_reg <= mode_next;
			cause_reg <= cause_next;
			on_sub_reg <= on_sub_next;
			pdf_reg <= pdf_next;
			to_reg <= to_next;
			pa_prev_reg <= porta_pins;
			if (halt_take)
				irq_mask_reg <= irq_req;
			rdata_reg <= rd_stb ? rd_mux : 8'h00;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			wdt_clear_reg <= 1'b0;
			sys_reset_reg <= 1'b0;
			wdt_reset_reg <= 1'b0;
			resume_reg <= 1'b0;
			irq_take_reg <= 1'b0;
		end
		else
		begin
			wdt_clear_reg <= halt_take;
			sys_reset_reg <= wake_done & (cause_reg == WK_RESET);
			// In run mode an overflow resets at once; in the switch and wake states it is ignored.
			wdt_reset_reg <= (wake_done & (cause_reg == WK_WDT))
				| ((mode_reg == OPM_RUN) & wdt_overflow);
			resume_reg <= wake_done & (cause_reg == WK_RESUME);
			irq_take_reg <= wake_done & (cause_reg == WK_IRQ);
		end
	end

	assign rdata = rdata_reg;
	assign osc_en = osc_en_w;
	assign int_low_osc_en = (allow_sub & ~slow_clk_src_sel) | wdt_enabled;
	assign int_high_osc_freq_sel = int_high_osc_freq_reg;
	assign high_clk_on = allow_high & high_stable;
	assign sub_clk_on = allow_sub & sub_stable;
	assign cpu_clk_on = (mode_reg == OPM_RUN);
	assign sys_on_sub = on_sub_reg;
	assign sys_div_sel = div_field;
	assign fast_src = fast_clk_src_sel;
	assign state_hold = low_pwr;
	assign wdt_clear = wdt_clear_reg;
	assign wdt_run = wdt_enabled & ~wdt_clear_reg;
	assign sys_reset_req = sys_reset_reg;
	assign wdt_reset_req = wdt_reset_reg;
	assign resume_next = resume_reg;
	assign irq_take = irq_take_reg;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	sequence s_halt;
		mode_reg == OPM_RUN && halt_exec;
	endsequence

	a_halt_sets_flags: assert property (s_halt |=> pdf_reg
		&& (!to_reg || $past(wdt_overflow)))
		else $error("halt flag update wrong");
	a_halt_wdt_clear: assert property (s_halt |=> wdt_clear
		##1 !wdt_clear) else $error("watchdog clear pulse wrong");
	a_sleep_entry: assert property (s_halt and (!hs_osc_halt_keep
		&& !ls_osc_halt_keep) |=> mode_reg == OPM_SLEEP && !high_clk_on
		&& !sub_clk_on && !cpu_clk_on) else $error("sleep entry wrong");
	a_idle_sub_only: assert property (mode_reg == OPM_IDLE_SUB_ONLY
		|-> !high_clk_on && !cpu_clk_on && osc_en[OSC_HXT] == 1'b0)
		else $error("sub-only idle clocks wrong");
	a_idle_both: assert property (s_halt and (hs_osc_halt_keep
		&& ls_osc_halt_keep) |=> mode_reg == OPM_IDLE_BOTH_CLOCKS && !cpu_clk_on)
		else $error("both-clocks idle entry wrong");
	a_idle_high_only: assert property (mode_reg == OPM_IDLE_HIGH_ONLY
		|-> !sub_clk_on && !cpu_clk_on && state_hold)
		else $error("high-only idle clocks wrong");
	a_stale_irq: assert property (low_pwr && irq_new == 0
		&& ext_rst_pin_n && !wdt_overflow && pa_fall == 0 |=> mode_reg
		== $past(mode_reg)) else $error("stale interrupt woke device");
	a_wake_gated: assert property (mode_reg == OPM_WAKE
		&& !sys_stable |-> !cpu_clk_on) else $error("cpu clock before stable");
	a_pin_reset_wake: assert property (low_pwr && rst_wake
		##1 sys_stable |=> sys_reset_req) else $error("pin wake reset missing");
	a_wdt_wake_flag: assert property (low_pwr && wdt_overflow
		|=> to_reg && mode_reg == OPM_WAKE) else $error("timeout wake wrong");
	a_slow_switch: assert property (mode_reg == OPM_RUN
		&& !halt_exec && !wr_scc && target_sub && !on_sub_reg && sub_stable
		|=> ##1 sys_on_sub) else $error("slow switch missing");
endmodule
`default_nettype wire

// *** logic/opm_pkg.sv ***
// Constants and types shared by the operating mode controller files.
package opm_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int NOSC = 3;
	localparam int NPA = 8;
	localparam int NIRQ = 8;

	localparam logic [3:0] OFF_SYS_CLOCK_CTRL = 4'h0;
	localparam logic [3:0] OFF_INT_HIGH_OSC_CTRL = 4'h1;
	localparam logic [3:0] OFF_EXT_HIGH_OSC_CTRL = 4'h2;
	localparam logic [3:0] OFF_EXT_LOW_OSC_CTRL = 4'h3;
	localparam logic [3:0] OFF_STATUS = 4'h4;
	localparam logic [3:0] OFF_PORTA_WAKE_EN = 4'h5;

	localparam int SCC_DIV_HI = 7;
	localparam int SCC_DIV_LO = 5;
	localparam int SCC_FAST_SRC = 3;
	localparam int SCC_SLOW_SRC = 2;
	localparam int SCC_HS_KEEP = 1;
	localparam int SCC_LS_KEEP = 0;
	localparam logic [7:0] SCC_MASK = 8'hef;

	localparam int OSC_EN_BIT = 0;
	localparam int OSC_STABLE_BIT = 1;
	localparam int INT_HIGH_OSC_FREQ_LO = 2;
	localparam int INT_HIGH_OSC_FREQ_HI = 3;
	localparam logic [7:0] LXT_READ_ONE = 8'h04;

	localparam int STAT_HALT = 0;
	localparam int STAT_WDT = 1;
	localparam int STAT_MODE_LO = 2;

	localparam logic [7:0] SCC_RST = 8'h00;
	localparam logic INT_HIGH_OSC_EN_RST = 1'b1;
	localparam logic [1:0] INT_HIGH_OSC_FREQ_RST = 2'b00;
	localparam logic HXT_EN_RST = 1'b0;
	localparam logic LXT_EN_RST = 1'b0;
	localparam logic [7:0] PORTA_WAKE_EN_RST = 8'h00;

	localparam logic [2:0] DIV_SUB = 3'h7;
	localparam int OSC_INT_HIGH_OSC = 0;
	localparam int OSC_HXT = 1;
	localparam int OSC_LXT = 2;

	typedef enum logic [2:0] {
		OPM_RUN, OPM_SWITCH, OPM_SLEEP, OPM_IDLE_SUB_ONLY,
		OPM_IDLE_BOTH_CLOCKS, OPM_IDLE_HIGH_ONLY, OPM_WAKE
	} opm_mode_t;

	typedef enum logic [1:0] {
		WK_RESUME, WK_IRQ, WK_WDT, WK_RESET
	} opm_wake_t;
endpackage

// *** logic/opm_osc_if.sv ***
// Signals between the controller and one oscillator stable tracker.
`timescale 1ns/10ps
`default_nettype none
interface opm_osc_if;
	logic en;
	logic restart;
	logic rdy;
	logic stable;
	modport trk (input en, input restart, input rdy, output stable);
	modport ctl (output en, output restart, output rdy, input stable);
endinterface
`default_nettype wire

// *** logic/opm_osc_stable.sv ***
// Stable flag tracker for one oscillator.
`timescale 1ns/10ps
`default_nettype none
module opm_osc_stable
(
	input wire logic clk,
	input wire logic reset,
	opm_osc_if.trk osc
);
	logic en_d_reg;
	logic stable_reg;
	logic stable_next;
	wire restart_now = (osc.en & ~en_d_reg) | osc.restart;

	// A restart forces one low cycle even if the ready input never drops.
	assign stable_next = restart_now ? 1'b0 : (osc.en & osc.rdy);
	assign osc.stable = stable_reg;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			en_d_reg <= 1'b0;
			stable_reg <= 1'b0;
		end
		else
		begin
			en_d_reg <= osc.en;
			stable_reg <= stable_next;
		end
	end
endmodule
`default_nettype wire

// *** testbench/opm_osc_model.sv ***
// Oscillator model: raises ready a set number of cycles after enable.
`timescale 1ns/10ps
`default_nettype none
module opm_osc_model
#(
	parameter int FAST_DLY = 3,
	parameter int SLOW_DLY = 40
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [opm_pkg::NOSC-1:0] osc_en,
	output logic [opm_pkg::NOSC-1:0] osc_rdy
);
	import opm_pkg::*;
	logic [7:0] cnt_reg [NOSC];
	// The internal high oscillator settles fast and the crystals slowly, so
	// the controller meets both a prompt and a late stable oscillator.
	always_ff @(posedge clk)
	begin
		for (int i = 0; i < NOSC; i++)
		begin
			if (reset || !osc_en[i])
			begin
				cnt_reg[i] <= 8'h00;
				osc_rdy[i] <= 1'h0;
			end
			else if (cnt_reg[i] == 8'((i == OSC_INT_HIGH_OSC) ? FAST_DLY : SLOW_DLY))
				osc_rdy[i] <= 1'h1;
			else
				cnt_reg[i] <= cnt_reg[i] + 8'h01;
		end
	end
endmodule
`default_nettype wire

// *** testbench/operating_mode_power_control_tb_top.sv ***
// Self-checking bench for the operating mode controller.
`timescale 1ns/10ps
`default_nettype none
module operating_mode_power_control_tb_top;
	import opm_pkg::*;
	typedef struct packed
	{
		logic w;
		logic [3:0] a;
		logic [7:0] d;
		logic [7:0] e;
	} opm_row_t;
	logic clk = 1'h0;
	logic reset = 1'h1;
	logic [ADDR_W-1:0] addr = 4'h0;
	logic [DATA_W-1:0] wdata = 8'h00;
	logic [DATA_W-1:0] rdata;
	logic wr_stb = 1'h0, rd_stb = 1'h0, halt_exec = 1'h0, clr_wdt_exec = 1'h0;
	logic ext_rst_pin_n = 1'h1, stack_full = 1'h0;
	logic wdt_enabled = 1'h1, wdt_overflow = 1'h0;
	logic [NPA-1:0] porta_pins = 8'hff;
	logic [NIRQ-1:0] irq_req = 8'h00, irq_en = 8'h00;
	logic [NOSC-1:0] osc_rdy, osc_en;
	logic int_low_osc_en, high_clk_on, sub_clk_on, cpu_clk_on, sys_on_sub;
	logic [1:0] int_high_osc_freq_sel;
	logic [2:0] sys_div_sel;
	logic fast_src, state_hold, wdt_clear, wdt_run;
	logic sys_reset_req, wdt_reset_req, resume_next, irq_take;
	logic [3:0] pulses;
	int mismatches = 0;
	int comparisons = 0;
	opm_row_t rows [13] = '{
		{1'h0, 4'h0, 8'h00, 8'h00}, {1'h0, 4'h1, 8'h00, 8'h03},
		{1'h0, 4'h2, 8'h00, 8'h00}, {1'h0, 4'h3, 8'h00, 8'h04},
		{1'h0, 4'h4, 8'h00, 8'h00}, {1'h0, 4'h5, 8'h00, 8'h00},
		{1'h1, 4'h0, 8'hff, 8'hef}, {1'h1, 4'h0, 8'h00, 8'h00},
		{1'h1, 4'h5, 8'ha5, 8'ha5}, {1'h1, 4'h3, 8'hf8, 8'h04},
		{1'h1, 4'h4, 8'hff, 8'h00}, {1'h1, 4'h9, 8'hff, 8'h00},
		{1'h1, 4'h5, 8'h01, 8'h01}
	};

	assign pulses = {sys_reset_req, wdt_reset_req, irq_take, resume_next};

	opm_ctrl DUT (.clk, .reset, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
		.halt_exec, .clr_wdt_exec, .ext_rst_pin_n, .porta_pins, .irq_req,
		.irq_en, .stack_full, .wdt_enabled, .wdt_overflow, .osc_rdy, .osc_en,
		.int_low_osc_en, .int_high_osc_freq_sel, .high_clk_on, .sub_clk_on,
		.cpu_clk_on, .sys_on_sub, .sys_div_sel, .fast_src, .state_hold,
		.wdt_clear, .wdt_run, .sys_reset_req, .wdt_reset_req, .resume_next,
		.irq_take);
	opm_osc_model #(.FAST_DLY(3), .SLOW_DLY(40)) partner (.clk, .reset,
		.osc_en, .osc_rdy);

	always #4 clk = ~clk;

	task chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'h1;
		@(posedge clk);
		wr_stb <= 1'h0;
	endtask

	task rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd_stb <= 1'h1;
		@(posedge clk);
		rd_stb <= 1'h0;
		#1;
		chk(rdata, e);
	endtask

	// Gates, hold and watchdog clear are looked at in the cycle after halt.
	task halt(input logic [1:0] k);
		wr(OFF_SYS_CLOCK_CTRL, {6'h00, k});
		@(posedge clk);
		halt_exec <= 1'h1;
		@(posedge clk);
		halt_exec <= 1'h0;
		#1;
		chk({2'h0, high_clk_on, sub_clk_on, cpu_clk_on, state_hold,
			wdt_clear, wdt_run}, {2'h0, k, 4'h6});
	endtask

	// The cause pulse must coincide with the CPU clock coming back.
	task wait_wake(input logic [3:0] exp);
		int n;
		n = 0;
		#1;
		while (pulses === 4'h0 && n < 300)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		chk({pulses, cpu_clk_on}, {exp, 1'h1});
		@(posedge clk);
	endtask

	task give_verdict;
		if (mismatches == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial
	begin
		#100000;
		mismatches++;
		give_verdict();
	end

	initial
	begin
		repeat (16) @(posedge clk);
		reset <= 1'h0;
		repeat (10) @(posedge clk);
		foreach (rows[i])
		begin
			if (rows[i].w)
				wr(rows[i].a, rows[i].d);
			rd(rows[i].a, rows[i].e);
		end
		wr(OFF_SYS_CLOCK_CTRL, 8'he0);
		repeat (3) @(posedge clk);
		#1;
		chk({sys_on_sub, sys_div_sel}, 8'h0f);
		wr(OFF_SYS_CLOCK_CTRL, 8'h40);
		repeat (3) @(posedge clk);
		#1;
		chk({sys_on_sub, sys_div_sel}, 8'h02);
		// The crystal is still settling, so the switch has to wait for it.
		wr(OFF_EXT_LOW_OSC_CTRL, 8'h01);
		wr(OFF_SYS_CLOCK_CTRL, 8'he4);
		repeat (3) @(posedge clk);
		#1;
		chk(sys_on_sub, 8'h00);
		repeat (60) @(posedge clk);
		#1;
		chk({sys_on_sub, osc_en[OSC_LXT]}, 8'h03);
		wr(OFF_SYS_CLOCK_CTRL, 8'h00);
		repeat (3) @(posedge clk);
		#1;
		chk(sys_on_sub, 8'h00);
		// An unstarted crystal chosen as fast source keeps the high clock gated.
		wr(OFF_SYS_CLOCK_CTRL, 8'h08);
		#1;
		chk({fast_src, high_clk_on}, 8'h02);
		wr(OFF_SYS_CLOCK_CTRL, 8'h00);
		for (int k = 0; k < 4; k++)
		begin
			halt(2'(k));
			@(posedge clk);
			porta_pins <= 8'hfe;
			wdt_enabled <= k[1];
			#1;
			chk({wdt_run, int_low_osc_en}, {k[1], k[1] | k[0]});
			wait_wake(4'h1);
			porta_pins <= 8'hff;
			rd(OFF_STATUS, 8'h01);
		end
		@(posedge clk);
		irq_req <= 8'h01;
		irq_en <= 8'h02;
		for (int j = 0; j < 2; j++)
		begin
			@(posedge clk);
			stack_full <= (j == 0);
			halt(2'h3);
			repeat (20) @(posedge clk);
			#1;
			chk({pulses, cpu_clk_on}, 8'h00);
			@(posedge clk);
			irq_req <= 8'h03;
			wait_wake((j == 0) ? 4'h1 : 4'h2);
			irq_req <= 8'h01;
		end
		halt(2'h0);
		@(posedge clk);
		wdt_overflow <= 1'h1;
		@(posedge clk);
		wdt_overflow <= 1'h0;
		wait_wake(4'h4);
		rd(OFF_STATUS, 8'h03);
		@(posedge clk);
		clr_wdt_exec <= 1'h1;
		@(posedge clk);
		clr_wdt_exec <= 1'h0;
		rd(OFF_STATUS, 8'h02);
		halt(2'h2);
		@(posedge clk);
		ext_rst_pin_n <= 1'h0;
		wait_wake(4'h8);
		ext_rst_pin_n <= 1'h1;
		rd(OFF_STATUS, 8'h01);
		// A frequency change must show one unstable read right after it.
		wr(OFF_INT_HIGH_OSC_CTRL, 8'h05);
		addr <= OFF_INT_HIGH_OSC_CTRL;
		rd_stb <= 1'h1;
		@(posedge clk);
		rd_stb <= 1'h0;
		#1;
		chk(rdata, 8'h05);
		chk(int_high_osc_freq_sel, 8'h01);
		rd(OFF_INT_HIGH_OSC_CTRL, 8'h07);
		// A second reset mid-run clears the halt flag and the frequency.
		@(posedge clk);
		reset <= 1'h1;
		repeat (2) @(posedge clk);
		reset <= 1'h0;
		rd(OFF_STATUS, 8'h00);
		rd(OFF_INT_HIGH_OSC_CTRL, 8'h01);
		give_verdict();
	end
endmodule
`default_nettype wire
